// ### hdl/lbf_regs.svh
`ifndef LBF_REGS_SVH
`define LBF_REGS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define LBF_CTRL_ADDR 8'hB7
`define LBF_STAT_ADDR 8'hD7
`define LBF_CTRL_RESET 8'h00
`define LBF_STAT_RESET 4'h0
`define LBF_RDATA_UNMAPPED 8'h00

// ----------------------------------------------------------------
// field layout of the response control byte
// ----------------------------------------------------------------
`define LBF_FIELD_W 2
`define LBF_NUM_FAULTS 4
`define LBF_OUT_OV_LSB 0
`define LBF_OUT_UV_LSB 2
`define LBF_IN_OV_LSB 4
`define LBF_IN_UV_LSB 6

// ----------------------------------------------------------------
// field encodings; the two remaining codes both mean flag only
// ----------------------------------------------------------------
`define LBF_CODE_HICCUP 2'h1
`define LBF_CODE_LATCH 2'h2

// ----------------------------------------------------------------
// voltage status byte bit positions
// ----------------------------------------------------------------
`define LBF_ST_OUT_OV 0
`define LBF_ST_OUT_UV 1
`define LBF_ST_IN_OV 2
`define LBF_ST_IN_UV 3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LBF_MCLK_HZ 25000000
`define LBF_HICCUP_MS 500
`define LBF_HICCUP_CYCLES ((`LBF_MCLK_HZ / 1000) * `LBF_HICCUP_MS)
`define LBF_HICCUP_CNT_W 24

`endif

// ### hdl/lbf_pkg.sv
`include "lbf_regs.svh"

package lbf_pkg;

  // response selected for one fault
  typedef enum logic [1:0] {
    LBF_RESP_FLAG,
    LBF_RESP_HICCUP,
    LBF_RESP_LATCH
  } lbf_resp_e;

  // per-fault response state
  typedef enum logic [1:0] {
    LBF_ST_RUN,
    LBF_ST_HICCUP,
    LBF_ST_LATCHED
  } lbf_state_e;

  // map a 2-bit field onto a response; 00 and 11 both flag only
  function automatic lbf_resp_e lbf_decode(input logic [1:0] code);
    lbf_resp_e r;
    r = LBF_RESP_FLAG;
    case (code)
      `LBF_CODE_HICCUP: r = LBF_RESP_HICCUP;
      `LBF_CODE_LATCH: r = LBF_RESP_LATCH;
      default: r = LBF_RESP_FLAG;
    endcase
    return r;
  endfunction

endpackage

// ### hdl/lbf_fault_resp.sv
`timescale 1ns/1ps
`include "lbf_regs.svh"

module lbf_fault_resp
  import lbf_pkg::*;
#(
  parameter int CNT_W = `LBF_HICCUP_CNT_W,
  parameter int HICCUP_CYCLES = `LBF_HICCUP_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // fault and selected response
  input wire logic fault,
  input wire lbf_resp_e resp,
  input wire logic restart,
  // switching stop request
  output logic halt
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(HICCUP_CYCLES - 1);

  // refuse a delay the counter cannot hold
  if (HICCUP_CYCLES < 1 || HICCUP_CYCLES > (2 ** CNT_W)) begin : g_chk
    $error("hiccup delay does not fit the counter");
  end

  typedef struct packed {
    lbf_state_e state;
    logic [CNT_W-1:0] cnt;
    logic halt;
  } lbf_fr_s;

  lbf_fr_s r_reg;
  lbf_fr_s r_next;

  // response state machine
  always_comb begin
    r_next = r_reg;
    case (r_reg.state)
      LBF_ST_RUN: begin
        if (fault && resp == LBF_RESP_HICCUP) begin
          r_next.state = LBF_ST_HICCUP;
          r_next.cnt = '0;
          r_next.halt = 1'b1;
        end else if (fault && resp == LBF_RESP_LATCH) begin
          r_next.state = LBF_ST_LATCHED;
          r_next.halt = 1'b1;
        end
      end
      LBF_ST_HICCUP: begin
        // a returning fault starts the wait over
        if (fault) begin
          r_next.cnt = '0;
        end else if (r_reg.cnt == LAST) begin
          r_next.state = LBF_ST_RUN;
          r_next.cnt = '0;
          r_next.halt = 1'b0;
        end else begin
          r_next.cnt = r_reg.cnt + 1'b1;
        end
      end
      LBF_ST_LATCHED: begin
        // only a pin toggle leaves; a live fault relatches next cycle
        if (restart) begin
          r_next.state = LBF_ST_RUN;
          r_next.halt = 1'b0;
        end
      end
      default: begin
        r_next.state = LBF_ST_RUN;
        r_next.halt = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '{state: LBF_ST_RUN, cnt: '0, halt: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign halt = r_reg.halt;

  sequence hic_clear_s;
    r_reg.state == LBF_ST_HICCUP && fault ##1 !fault;
  endsequence

  hiccup_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    hic_clear_s |-> halt ##1 halt)
    else $error("hiccup released right after fault cleared");

  hiccup_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (r_reg.state == LBF_ST_HICCUP && !fault && r_reg.cnt == LAST)
      |=> !halt && r_reg.state == LBF_ST_RUN)
    else $error("hiccup did not end at terminal count");

  latch_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (r_reg.state == LBF_ST_LATCHED && !restart) |=> halt)
    else $error("latch-off released without toggle");

  latch_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (r_reg.state == LBF_ST_LATCHED && restart) |=> !halt)
    else $error("latch-off ignored restart toggle");

  flag_only_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (r_reg.state == LBF_ST_RUN && resp == LBF_RESP_FLAG) |=> !halt)
    else $error("flag-only response stopped switching");

endmodule

// ### hdl/lbf_fault_resp_ctrl.sv
// Operation
// - The response control byte is eight read/write bits that reset to zero.
// - With the global enable set, each fault takes its response from the byte.
// - With the global enable clear, responses come from the strap setting.
// - Codes 00 and 11 only record the fault and keep switching running.
// - Every fault sets its status bit and pulls the fault flag pin low.
// - Code 01 stops switching and resumes 500 ms after the fault clears.
// - Code 10 stops switching and stays stopped when the fault clears.
// - After latch-off, a toggle of the switching or chip enable pin restarts.
// - Faults are taken from the second-level threshold comparators.
// - Bits 1:0 are output overvoltage, reported in status bit 0.
// - Bits 3:2 are output undervoltage, reported in status bit 1.
// - Bits 5:4 are input overvoltage, reported in status bit 2.
// - Bits 7:6 are input undervoltage with the same encoding.
// - Input undervoltage sets status bit 3 and follows bits 7:6.

`timescale 1ns/1ps
`include "lbf_regs.svh"

module lbf_fault_resp_ctrl
  import lbf_pkg::*;
#(
  parameter int HICCUP_CYCLES = `LBF_HICCUP_CYCLES,
  parameter int CNT_W = `LBF_HICCUP_CNT_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // management bus register access
  input wire logic [7:0] mgmt_addr,
  input wire logic [7:0] mgmt_wdata,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  output logic [7:0] mgmt_rdata,
  // global selection, same clock domain
  input wire logic ind_resp_en,
  input wire logic [7:0] strap_resp,
  // second-level comparator outputs, asynchronous
  input wire logic [3:0] fault_lvl2,
  // enable pins, asynchronous
  input wire logic pwm_en_pin,
  input wire logic chip_en_pin,
  // status and control outputs
  output logic [3:0] volt_status,
  output logic fault_flag_n_pin,
  output logic switching_on
);

  localparam int NF = `LBF_NUM_FAULTS;
  localparam int FW = `LBF_FIELD_W;

  if (NF * FW != 8) begin : g_chk
    $error("fault fields must fill the control byte");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [3:0] status;
    logic [7:0] rdata;
    logic [3:0] fault_meta;
    logic [3:0] fault_sync;
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] pin_last;
    logic flag_n;
    logic sw_on;
  } lbf_top_s;

  lbf_top_s r_reg;
  lbf_top_s r_next;

  logic [7:0] field_sel;
  lbf_resp_e resp [NF];
  logic [NF-1:0] halt;
  logic restart;
  logic ctrl_wr;
  logic stat_clr_wr;

  // ----------------------------------------------------------------
  // decode and response selection
  // ----------------------------------------------------------------

  // register strobes on exact address match only
  assign ctrl_wr = mgmt_wr && (mgmt_addr == `LBF_CTRL_ADDR);
  assign stat_clr_wr = mgmt_wr && (mgmt_addr == `LBF_STAT_ADDR);

  // global enable picks register fields or strap fields
  assign field_sel = ind_resp_en ? r_reg.ctrl : strap_resp;

  // any edge on either synchronised enable pin counts as a toggle
  assign restart = |(r_reg.pin_sync ^ r_reg.pin_last);

  // ----------------------------------------------------------------
  // per-fault response engines
  // ----------------------------------------------------------------
  // fault index i uses field bits [2i+1:2i] and status bit i, so
  // out-ov, out-uv, in-ov, in-uv land on 1:0, 3:2, 5:4, 7:6
  for (genvar i = 0; i < NF; i++) begin : g_fault
    assign resp[i] = lbf_decode(field_sel[i*FW +: FW]);

    lbf_fault_resp #(
      .CNT_W(CNT_W),
      .HICCUP_CYCLES(HICCUP_CYCLES)
    ) u_resp (
      .mclk(mclk),
      .rst_n(rst_n),
      .fault(r_reg.fault_sync[i]),
      .resp(resp[i]),
      .restart(restart),
      .halt(halt[i])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;

    // two-stage synchronisers; first stage feeds only the second
    r_next.fault_meta = fault_lvl2;
    r_next.fault_sync = r_reg.fault_meta;
    r_next.pin_meta = {chip_en_pin, pwm_en_pin};
    r_next.pin_sync = r_reg.pin_meta;
    r_next.pin_last = r_reg.pin_sync;

    // control byte write, all eight bits stored
    if (ctrl_wr) begin
      r_next.ctrl = mgmt_wdata;
    end

    // write-one clears status; a fault in the same cycle wins
    r_next.status = r_reg.status;
    if (stat_clr_wr) begin
      r_next.status = r_reg.status & ~mgmt_wdata[3:0];
    end
    r_next.status = r_next.status | r_reg.fault_sync;

    // flag pin follows the status bits, low while any is set
    r_next.flag_n = ~|r_next.status;

    // switching runs while both enables are high and nothing halts
    r_next.sw_on = &r_reg.pin_sync & ~|halt;

    // read data registered; unmapped addresses read zero
    if (mgmt_rd) begin
      case (mgmt_addr)
        `LBF_CTRL_ADDR: r_next.rdata = r_reg.ctrl;
        `LBF_STAT_ADDR: r_next.rdata = {4'h0, r_reg.status};
        default: r_next.rdata = `LBF_RDATA_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg.ctrl <= `LBF_CTRL_RESET;
      r_reg.status <= `LBF_STAT_RESET;
      r_reg.rdata <= 8'h00;
      r_reg.fault_meta <= 4'h0;
      r_reg.fault_sync <= 4'h0;
      // pins idle high; resetting to the idle level avoids a false toggle
      r_reg.pin_meta <= 2'h3;
      r_reg.pin_sync <= 2'h3;
      r_reg.pin_last <= 2'h3;
      r_reg.flag_n <= 1'b1;
      r_reg.sw_on <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, straight from flip-flops
  // ----------------------------------------------------------------
  assign mgmt_rdata = r_reg.rdata;
  assign volt_status = r_reg.status;
  assign fault_flag_n_pin = r_reg.flag_n;
  assign switching_on = r_reg.sw_on;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // write, one idle cycle, then a read of the control byte
  sequence ctrl_write_s;
    ctrl_wr ##1 !ctrl_wr
      ##1 (mgmt_rd && mgmt_addr == `LBF_CTRL_ADDR && !ctrl_wr);
  endsequence

  ctrl_store_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl_wr |=> r_reg.ctrl == $past(mgmt_wdata))
    else $error("control byte write not stored");

  ctrl_readback_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl_write_s |=> mgmt_rdata == $past(mgmt_wdata, 3))
    else $error("control byte readback mismatch");

  strap_select_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !ind_resp_en |-> field_sel == strap_resp)
    else $error("strap setting not used with enable clear");

  reg_select_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ind_resp_en |-> resp[0] == lbf_decode(r_reg.ctrl[1:0]))
    else $error("register field not used with enable set");

  status_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_lvl2[3] ##1 fault_lvl2[3] |-> ##2 volt_status[3])
    else $error("input undervoltage did not set status bit 3");

  flag_pin_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (volt_status != 4'h0) |-> !fault_flag_n_pin)
    else $error("fault flag pin high while status set");

  halt_stops_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (|halt) |=> !switching_on)
    else $error("switching on while a response halts it");

  // ----------------------------------------------------------------
  // read path checks
  // ----------------------------------------------------------------

  // unmapped addresses must not leak internal state
  rdata_unmap_a: assert property (
    mgmt_rd && mgmt_addr != `LBF_CTRL_ADDR && mgmt_addr != `LBF_STAT_ADDR
      |=> mgmt_rdata == `LBF_RDATA_UNMAPPED)
    else $error("unmapped read returned nonzero data");

  // read returns the byte as it stood before any same-cycle write
  ctrl_read_a: assert property (
    mgmt_rd && mgmt_addr == `LBF_CTRL_ADDR |=> mgmt_rdata == $past(r_reg.ctrl))
    else $error("control byte read wrong");

  // status read shows the four bits with the upper nibble zero
  stat_read_a: assert property (
    mgmt_rd && mgmt_addr == `LBF_STAT_ADDR
      |=> mgmt_rdata == {4'h0, $past(volt_status)})
    else $error("status byte read wrong");

  // read data has no valid strobe, so it must hold between reads
  rdata_hold_a: assert property (
    !mgmt_rd |=> $stable(mgmt_rdata))
    else $error("read data changed without a read");

  // control byte only changes on a write to its own address
  ctrl_hold_a: assert property (
    !ctrl_wr |=> $stable(r_reg.ctrl))
    else $error("control byte changed without a write");

  // ----------------------------------------------------------------
  // status and flag checks
  // ----------------------------------------------------------------

  // status bits are sticky unless the host clears them
  stat_sticky_a: assert property (
    !stat_clr_wr |=> (volt_status & $past(volt_status)) == $past(volt_status))
    else $error("status bit dropped without a clear");

  // a clear with no live fault empties the written bits
  stat_clear_a: assert property (
    stat_clr_wr && r_reg.fault_sync == 4'h0
      |=> (volt_status & $past(mgmt_wdata[3:0])) == 4'h0)
    else $error("status clear did not take");

  // a live fault always lands in its status bit, clear or not
  fault_sets_a: assert property (
    (|r_reg.fault_sync)
      |=> (volt_status & $past(r_reg.fault_sync)) == $past(r_reg.fault_sync))
    else $error("live fault missing from status");

  // flag pin releases once every status bit is gone
  flag_clear_a: assert property (
    volt_status == 4'h0 |-> fault_flag_n_pin)
    else $error("fault flag pin low with status clear");

  // ----------------------------------------------------------------
  // switching and selection checks
  // ----------------------------------------------------------------

  // a low enable pin always stops switching
  sw_needs_pins_a: assert property (
    !(&r_reg.pin_sync) |=> !switching_on)
    else $error("switching on with an enable pin low");

  // nothing halting and both pins high means switching runs
  sw_runs_a: assert property (
    (&r_reg.pin_sync) && !(|halt) |=> switching_on)
    else $error("switching stopped with no response active");

  // any synchronised pin edge is a restart request
  restart_edge_a: assert property (
    r_reg.pin_sync != r_reg.pin_last |-> restart)
    else $error("pin toggle not seen as restart");

  // output undervoltage takes bits 3:2
  reg_field1_a: assert property (
    ind_resp_en |-> resp[1] == lbf_decode(r_reg.ctrl[3:2]))
    else $error("output undervoltage field not used");

  // input overvoltage takes bits 5:4
  reg_field2_a: assert property (
    ind_resp_en |-> resp[2] == lbf_decode(r_reg.ctrl[5:4]))
    else $error("input overvoltage field not used");

  // input undervoltage takes bits 7:6
  reg_field3_a: assert property (
    ind_resp_en |-> resp[3] == lbf_decode(r_reg.ctrl[7:6]))
    else $error("input undervoltage field not used");

  // strap setting drives the top field when the enable is clear
  strap_field3_a: assert property (
    !ind_resp_en |-> resp[3] == lbf_decode(strap_resp[7:6]))
    else $error("strap field not used for input undervoltage");

endmodule

// ### tb/lbf_host_model.sv
`timescale 1ns/1ps

module lbf_host_model (
  // clock
  input wire logic mclk,
  // management bus
  output logic [7:0] mgmt_addr,
  output logic [7:0] mgmt_wdata,
  output logic mgmt_wr,
  output logic mgmt_rd,
  input wire logic [7:0] mgmt_rdata,
  // enable pins
  output logic pwm_en_pin,
  output logic chip_en_pin
);
  // idle bus, both enable pins asserted
  initial begin
    mgmt_addr = 8'h00;
    mgmt_wdata = 8'h00;
    mgmt_wr = 1'h0;
    mgmt_rd = 1'h0;
    pwm_en_pin = 1'h1;
    chip_en_pin = 1'h1;
  end

  // one strobe cycle, then an idle cycle so back-to-back calls stay clean
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = 1'h1;
    @(negedge mclk);
    mgmt_wr = 1'h0;
    mgmt_wdata = ~d; // stale data must never pass for valid
    @(negedge mclk);
  endtask

  // read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    mgmt_addr = a;
    mgmt_rd = 1'h1;
    @(negedge mclk);
    mgmt_rd = 1'h0;
    d = mgmt_rdata;
    @(negedge mclk);
  endtask

  // restart after latch-off: pulse one enable pin low
  task automatic toggle(input logic chip);
    if (chip) chip_en_pin = 1'h0;
    else pwm_en_pin = 1'h0;
    repeat (3) @(negedge mclk);
    chip_en_pin = 1'h1;
    pwm_en_pin = 1'h1;
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "lbf_regs.svh"

module testbench;
  // short hiccup wait keeps the run brief
  localparam int HC = 20;
  logic mclk, rst_n, ind_resp_en, mgmt_wr, mgmt_rd;
  logic pwm_en_pin, chip_en_pin, fault_flag_n_pin, switching_on;
  logic [7:0] mgmt_addr, mgmt_wdata, mgmt_rdata, strap_resp, rd_val;
  logic [3:0] fault_lvl2, volt_status;
  int mismatches, n_compared;

  // free-running clock
  always #20 mclk = ~mclk;

  lbf_host_model host (.mclk(mclk), .mgmt_addr(mgmt_addr),
    .mgmt_wdata(mgmt_wdata), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_rdata(mgmt_rdata), .pwm_en_pin(pwm_en_pin),
    .chip_en_pin(chip_en_pin));

  lbf_fault_resp_ctrl #(.HICCUP_CYCLES(HC)) DUT (.mclk(mclk),
    .rst_n(rst_n), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata),
    .ind_resp_en(ind_resp_en), .strap_resp(strap_resp),
    .fault_lvl2(fault_lvl2), .pwm_en_pin(pwm_en_pin),
    .chip_en_pin(chip_en_pin), .volt_status(volt_status),
    .fault_flag_n_pin(fault_flag_n_pin), .switching_on(switching_on));

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rd_val);
    chk(rd_val, exp);
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // one fault through detect, response, recovery and status clear
  // ----------------------------------------------------------------
  task automatic run_case(input int f, input logic [1:0] code);
    logic [7:0] b;
    logic stops;
    b = 8'h01 << f;
    stops = (code == 2'h1) || (code == 2'h2);
    fault_lvl2 = b[3:0];
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk({4'h0, volt_status}, b);
    chk({7'h00, fault_flag_n_pin}, 8'h00);
    chk({7'h00, switching_on}, {7'h00, ~stops});
    host.wr(`LBF_STAT_ADDR, b);
    rdchk(`LBF_STAT_ADDR, b);
    fault_lvl2 = 4'h0;
    repeat (HC / 2) @(negedge mclk);
    chk({7'h00, switching_on}, {7'h00, ~stops});
    repeat (HC + 10) @(negedge mclk);
    chk({7'h00, switching_on}, {7'h00, code != 2'h2});
    if (code == 2'h2) begin
      host.toggle(f[0]);
      repeat (8) @(negedge mclk);
      chk({7'h00, switching_on}, 8'h01);
    end
    host.wr(`LBF_STAT_ADDR, b);
    rdchk(`LBF_STAT_ADDR, 8'h00);
    chk({7'h00, fault_flag_n_pin}, 8'h01);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    rst_n = 1'h0;
    ind_resp_en = 1'h1;
    strap_resp = 8'h00;
    fault_lvl2 = 4'h0;
    mismatches = 0;
    n_compared = 0;
    repeat (20) @(negedge mclk);
    rst_n = 1'h1;
    repeat (4) @(negedge mclk);
    rdchk(`LBF_CTRL_ADDR, 8'h00);
    chk({7'h00, switching_on}, 8'h01);
    host.wr(`LBF_CTRL_ADDR, 8'hA5);
    rdchk(`LBF_CTRL_ADDR, 8'hA5);
    host.wr(`LBF_CTRL_ADDR, 8'h5A);
    rdchk(`LBF_CTRL_ADDR, 8'h5A);
    host.wr(8'hB6, 8'hFF);
    rdchk(`LBF_CTRL_ADDR, 8'h5A);
    rdchk(8'hB6, 8'h00);
    rdchk(`LBF_STAT_ADDR, 8'h00);
    $display("test registers done");
    // every code in every field, register selected
    for (int f = 0; f < 4; f++) begin
      for (int c = 0; c < 4; c++) begin
        host.wr(`LBF_CTRL_ADDR, 8'(c << (2 * f)));
        run_case(f, c[1:0]);
      end
    end
    $display("test field codes done");
    // strap setting wins while the global enable is clear
    ind_resp_en = 1'h0;
    host.wr(`LBF_CTRL_ADDR, 8'h55);
    strap_resp = 8'hAA;
    run_case(0, 2'h2);
    strap_resp = 8'h00;
    run_case(3, 2'h0);
    $display("test strap selection done");
    results;
  end

  // watchdog, far beyond the expected run of some 1070 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    results;
  end
endmodule
